// File: design/sample_fifo_pkg.sv
`default_nettype none
package sample_fifo_pkg;
  localparam logic [7:0] ADDR_STATUS    = 8'h00; // status / buffer status
  localparam logic [7:0] ADDR_DATA_HEAD = 8'h01; // buffer read port
  localparam logic [7:0] ADDR_ZERO_LO   = 8'h02;
  localparam logic [7:0] ADDR_ZERO_HI   = 8'h06;
  localparam logic [7:0] ADDR_SETUP     = 8'h09;
  localparam logic [7:0] ADDR_TRIG_CFG  = 8'h0A;
  localparam int         OVF_BIT        = 7;
  localparam int         LVL_BIT        = 6;
  localparam int         MODE_HI        = 7;
  localparam int         MODE_LO        = 6;
  localparam int         CNT_W          = 6;
  localparam int         DEPTH          = 32;
  localparam logic [5:0] CNT_FULL       = 6'h20;
  localparam logic [5:0] CNT_EMPTY      = 6'h00;
  localparam logic [7:0] SETUP_RESET    = 8'h00;
  localparam logic [7:0] TRIG_RESET     = 8'h00;
  localparam int         SAMPLE_W       = 8;
  typedef enum logic [1:0] {
    MODE_OFF,
    MODE_CIRC,
    MODE_FILL,
    MODE_TRIG
  } buf_mode_t;
  typedef enum logic [1:0] {
    ST_IDLE,
    ST_PRE,
    ST_POST,
    ST_STOP
  } trig_state_t;
endpackage
`default_nettype wire

// File: design/sample_mem.sv
`default_nettype none
module sample_mem
  import sample_fifo_pkg::*;
#(
  parameter int W = SAMPLE_W,
  parameter int D = DEPTH,
  parameter int A = 5
)(
  input  wire logic         sys_clk,
  input  wire logic         wr_en,
  input  wire logic [A-1:0] wr_addr,
  input  wire logic [W-1:0] wr_data,
  input  wire logic [A-1:0] rd_addr,
  output logic      [W-1:0] rd_data
);
  logic [W-1:0] mem [D];
  // registered read; no reset, storage only
  always_ff @(posedge sys_clk)
  begin
    if (wr_en)
    begin
      mem[wr_addr] <= wr_data;
    end
    rd_data <= mem[rd_addr];
  end
endmodule // sample_mem
`default_nettype wire

// File: design/trig_tracker.sv
`default_nettype none
module trig_tracker
  import sample_fifo_pkg::*;
(
  input  wire logic       sys_clk,
  input  wire logic       rstn,
  input  wire logic       arm,
  input  wire logic       trig_event,
  input  wire logic       sample_in,
  input  wire logic [5:0] threshold_value,
  output logic            triggered,
  output logic            stopped
);
  typedef struct packed {
    trig_state_t st;
    logic [5:0]  left;
  } trk_t;
  trk_t s_r;
  trk_t s_nxt;
  always_comb
  begin
    s_nxt = s_r;
    case (s_r.st)
      ST_IDLE:
      begin
        if (arm)
        begin
          s_nxt.st = ST_PRE;
        end
      end
      ST_PRE:
      begin
        if (trig_event)
        begin
          s_nxt.st   = ST_POST;
          s_nxt.left = 6'(CNT_FULL - threshold_value); // RULE10
        end
      end
      ST_POST:
      begin
        if (s_nxt.left == CNT_EMPTY)
        begin
          s_nxt.st = ST_STOP;
        end
        else if (sample_in)
        begin
          s_nxt.left = 6'(s_r.left - 6'h01);
          if (s_nxt.left == CNT_EMPTY)
          begin
            s_nxt.st = ST_STOP;
          end
        end
      end
      ST_STOP:
      begin
        s_nxt.st = ST_STOP;
      end
      default:
      begin
        s_nxt.st = ST_IDLE;
      end
    endcase
    if (!arm)
    begin
      s_nxt.st   = ST_IDLE;
      s_nxt.left = CNT_EMPTY;
    end
  end
  always_ff @(posedge sys_clk or negedge rstn)
  begin
    if (!rstn)
    begin
      s_r <= '{st: ST_IDLE, left: CNT_EMPTY};
    end
    else
    begin
      s_r <= s_nxt;
    end
  end
  assign triggered = (s_r.st == ST_POST) || (s_r.st == ST_STOP); // RULE11
  assign stopped   = (s_r.st == ST_STOP); // RULE8
endmodule // trig_tracker
`default_nettype wire

// File: design/sample_fifo_control.sv
// Operation
// (RULE1) nonzero mode puts the buffer status at address 0x00
// (RULE2) status: overflow bit 7, level flag bit 6, count bits 5..0
// (RULE3) count reads zero when empty, 1..32 for stored samples
// (RULE4) level flag set while count is at or above the threshold
// (RULE5) flags follow their cause; status reads do not clear them
// (RULE6) status read clears buffer irq bit; next sample sets it again
// (RULE7) trigger mode: overflow stays low until the trigger event
// (RULE8) trigger mode: overflow high means the buffer stopped accepting
// (RULE9) mode 00 off, 01 circular, 10 fill stops when full
// (RULE10) trigger mode: circular pre-trigger, then 32 minus threshold more
// (RULE11) trigger mode: level flag reports trigger detected
// (RULE12) flush on disable, rate change, standby-to-active; disable zeroes
// (RULE13) overflow flag asserts when count reaches 32
// (RULE14) threshold zero never raises the level flag
// (RULE15) mode writable any time; threshold writable only in standby
// (RULE16) host disables before switching between buffer modes
// (RULE17) count above threshold never stops sample intake
// (RULE18) samples arrive at the system output rate
// (RULE19) each byte read pops the oldest byte and counts down; a read in a cycle that drops the oldest returns 0x00 and pops nothing
// (RULE20) host drains the buffer with multibyte reads
// (RULE21) enabled: 0x01 serves buffer, 0x02..0x06 read as zero
// (RULE22) trigger event from embedded interrupts enabled at 0x0A
// (RULE23) count and flags update on the push or pop cycle
`default_nettype none
module sample_fifo_control
  import sample_fifo_pkg::*;
#(
  parameter int W = SAMPLE_W,
  parameter int A = 5
)(
  input  wire logic         sys_clk,
  input  wire logic         rstn,
  input  wire logic         active_mode,
  input  wire logic         rate_change,
  input  wire logic         sample_strobe,
  input  wire logic [W-1:0] sample_data,
  input  wire logic [7:0]   plain_status,
  input  wire logic [7:0]   plain_data,
  input  wire logic [3:0]   embedded_irqs,
  input  wire logic         reg_rd,
  input  wire logic         reg_wr,
  input  wire logic [7:0]   reg_addr,
  input  wire logic [7:0]   reg_wdata,
  output logic      [7:0]   reg_rdata,
  output logic              reg_rvalid,
  output logic              buffer_irq_bit,
  output logic              buffer_enabled
);
  typedef struct packed {
    logic [7:0]   setup;
    logic [7:0]   trig_cfg;
    logic [A-1:0] head;
    logic [A-1:0] tail;
    logic [5:0]   sample_count;
    logic         irq;
    logic         act_d;
    logic [3:0]   irq_d;
    logic         rd_pend;
    logic         rd_mem;
    logic [7:0]   rd_hold;
  } ctl_t;
  ctl_t s_r;
  ctl_t s_nxt;

  // reset image; setup and trigger cfg come up disabled
  localparam ctl_t CTL_RESET = '{
    setup:        SETUP_RESET,
    trig_cfg:     TRIG_RESET,
    head:         '0,
    tail:         '0,
    sample_count: CNT_EMPTY,
    irq:          1'b0,
    act_d:        1'b0,
    irq_d:        4'h0,
    rd_pend:      1'b0,
    rd_mem:       1'b0,
    rd_hold:      8'h00
  };

  logic         push;
  logic         pop;
  logic         drop_old;
  logic         flush;
  logic         trig_event;
  logic         triggered;
  logic         stopped;
  logic         overflow_flag;
  logic         level_flag;
  logic [W-1:0] mem_q;
  buf_mode_t    mode;
  logic [5:0]   level_threshold;
  logic [7:0]   status_byte;
  logic         setup_wr;
  logic         trig_wr;
  logic         status_rd;
  logic         head_rd;
  logic         grow;
  logic         flush_off;
  logic         flush_rate;
  logic         flush_wake;

  function automatic logic [A-1:0] ptr_inc(input logic [A-1:0] p);
    ptr_inc = A'(p + 1'b1);
  endfunction

  assign mode            = buf_mode_t'(s_r.setup[MODE_HI:MODE_LO]);
  assign level_threshold = s_r.setup[CNT_W-1:0];
  assign buffer_enabled  = (mode != MODE_OFF);

  // register strobes; 0x0A writes refused while active, like the threshold
  assign setup_wr  = reg_wr && (reg_addr == ADDR_SETUP);
  assign trig_wr   = reg_wr && (reg_addr == ADDR_TRIG_CFG) && !active_mode;
  assign status_rd = reg_rd && (reg_addr == ADDR_STATUS);
  assign head_rd   = reg_rd && (reg_addr == ADDR_DATA_HEAD);

  // rising edge of an enabled embedded interrupt fires the trigger
  assign trig_event = |(embedded_irqs & ~s_r.irq_d
                        & s_r.trig_cfg[5:2]); // RULE22

  trig_tracker u_trig (
    .sys_clk        (sys_clk),
    .rstn           (rstn),
    .arm            (mode == MODE_TRIG),
    .trig_event     (trig_event),
    .sample_in      (push),
    .threshold_value(level_threshold),
    .triggered      (triggered),
    .stopped        (stopped)
  );

  // flush on disable, rate switch or standby-to-active entry
  assign flush_off  = !buffer_enabled; // RULE12
  assign flush_rate = rate_change; // RULE12
  assign flush_wake = active_mode && !s_r.act_d; // RULE12
  assign flush      = flush_off || flush_rate || flush_wake;

  // intake policy per mode; the level threshold only limits intake in trigger mode
  always_comb
  begin
    push     = 1'b0;
    drop_old = 1'b0;
    if (sample_strobe && !flush) // RULE18
    begin
      case (mode)
        MODE_OFF:
        begin
          push     = 1'b0; // RULE9
          drop_old = 1'b0;
        end
        MODE_CIRC:
        begin
          push     = 1'b1; // RULE9 RULE17
          drop_old = (s_r.sample_count == CNT_FULL);
        end
        MODE_FILL:
        begin
          push = (s_r.sample_count != CNT_FULL); // RULE9
        end
        MODE_TRIG:
        begin
          if (!triggered)
          begin
            // pre-trigger window holds threshold samples; zero keeps none
            push     = (level_threshold != CNT_EMPTY); // RULE10
            drop_old = push && (s_r.sample_count >= level_threshold);
          end
          else
          begin
            push     = !stopped && (s_r.sample_count != CNT_FULL); // RULE10
            drop_old = 1'b0;
          end
        end
        default:
        begin
          push = 1'b0;
        end
      endcase
    end
  end

  assign pop = head_rd && buffer_enabled
               && (s_r.sample_count != CNT_EMPTY) && !drop_old; // RULE19
  assign grow = push && !drop_old;

  // overflow hidden in trigger mode until trigger completes
  always_comb
  begin
    case (mode)
      MODE_TRIG:
      begin
        overflow_flag = stopped; // RULE7 RULE8
        level_flag    = triggered; // RULE11
      end
      MODE_CIRC, MODE_FILL:
      begin
        overflow_flag = (s_r.sample_count == CNT_FULL); // RULE13
        level_flag    = (level_threshold != CNT_EMPTY) // RULE14
          && (s_r.sample_count >= level_threshold); // RULE4 RULE5
      end
      default:
      begin
        overflow_flag = 1'b0; // RULE12
        level_flag    = 1'b0; // RULE12
      end
    endcase
  end

  assign status_byte = {overflow_flag, level_flag, s_r.sample_count}; // RULE2

  always_comb
  begin
    s_nxt         = s_r;
    s_nxt.act_d   = active_mode;
    s_nxt.irq_d   = embedded_irqs;
    s_nxt.rd_pend = reg_rd;
    s_nxt.rd_mem  = 1'b0;
    if (setup_wr)
    begin
      s_nxt.setup[MODE_HI:MODE_LO] = reg_wdata[MODE_HI:MODE_LO]; // RULE15
      if (!active_mode)
      begin
        s_nxt.setup[CNT_W-1:0] = reg_wdata[CNT_W-1:0]; // RULE15
      end
    end
    if (trig_wr)
    begin
      s_nxt.trig_cfg = reg_wdata & 8'h3C;
    end
    if (reg_rd)
    begin
      if (reg_addr == ADDR_STATUS)
      begin
        s_nxt.rd_hold = buffer_enabled ? status_byte : plain_status; // RULE1
      end
      else if (reg_addr == ADDR_DATA_HEAD)
      begin
        s_nxt.rd_hold = buffer_enabled ? 8'h00 : plain_data;
        s_nxt.rd_mem  = pop; // RULE21
      end
      else if (reg_addr >= ADDR_ZERO_LO && reg_addr <= ADDR_ZERO_HI)
      begin
        s_nxt.rd_hold = 8'h00; // RULE21
      end
      else if (reg_addr == ADDR_SETUP)
      begin
        s_nxt.rd_hold = s_r.setup;
      end
      else if (reg_addr == ADDR_TRIG_CFG)
      begin
        s_nxt.rd_hold = s_r.trig_cfg;
      end
      else
      begin
        s_nxt.rd_hold = 8'h00;
      end
    end
    // status read clears irq bit; a push in the same cycle wins
    if (status_rd && buffer_enabled)
    begin
      s_nxt.irq = 1'b0; // RULE6
    end
    if (push)
    begin
      s_nxt.irq = 1'b1; // RULE6
    end
    // pointers and count move together in the same cycle
    if (push)
    begin
      s_nxt.tail = ptr_inc(s_r.tail);
    end
    if (pop || drop_old)
    begin
      s_nxt.head = ptr_inc(s_r.head);
    end
    // push and pop in one cycle leave the count alone
    case ({grow, pop})
      2'b10:
      begin
        s_nxt.sample_count = 6'(s_r.sample_count + 6'h01); // RULE23
      end
      2'b01:
      begin
        s_nxt.sample_count = 6'(s_r.sample_count - 6'h01); // RULE23
      end
      default:
      begin
        s_nxt.sample_count = s_r.sample_count;
      end
    endcase
    if (flush)
    begin
      s_nxt.head         = '0;
      s_nxt.tail         = '0;
      s_nxt.sample_count = CNT_EMPTY; // RULE3 RULE12
    end
    if (!buffer_enabled)
    begin
      s_nxt.irq = 1'b0; // RULE12
    end
  end

  always_ff @(posedge sys_clk or negedge rstn)
  begin
    if (!rstn)
    begin
      s_r <= CTL_RESET;
    end
    else
    begin
      s_r <= s_nxt;
    end
  end

  // memory read address is the head; data is ready one cycle later
  sample_mem #(.W(W), .D(DEPTH), .A(A)) u_mem (
    .sys_clk(sys_clk),
    .wr_en  (push),
    .wr_addr(s_r.tail),
    .wr_data(sample_data),
    .rd_addr(s_r.head),
    .rd_data(mem_q)
  );

  // mem_q holds head as of the read cycle, so popped byte is oldest
  assign reg_rdata      = s_r.rd_mem ? mem_q : s_r.rd_hold; // RULE19
  assign reg_rvalid     = s_r.rd_pend;
  assign buffer_irq_bit = s_r.irq;
endmodule // sample_fifo_control
`default_nettype wire

// File: tb/fifo_chk_sva.sv
`default_nettype none
module fifo_chk
  import sample_fifo_pkg::*;
(
  input wire logic       sys_clk,
  input wire logic       rstn,
  input wire logic       active_mode,
  input wire logic       sample_strobe,
  input wire logic [7:0] plain_status,
  input wire logic       reg_rd,
  input wire logic       reg_wr,
  input wire logic [7:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic [7:0] reg_rdata,
  input wire logic       buffer_irq_bit,
  input wire logic       buffer_enabled
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [1:0] md_r;
  logic [5:0] thr_r;
  logic       st, pl, zr, nt, tr, sw, full, ge;
  default clocking @(posedge sys_clk); endclocking
  default disable iff (!rstn);
  assign st = reg_rd && reg_addr == ADDR_STATUS && buffer_enabled;
  assign pl = reg_rd && reg_addr == ADDR_STATUS && !buffer_enabled;
  assign zr = reg_rd && buffer_enabled &&
              reg_addr inside {[ADDR_ZERO_LO:ADDR_ZERO_HI]};
  assign nt = st && md_r != MODE_TRIG;
  assign tr = st && md_r == MODE_TRIG;
  assign sw = reg_wr && reg_addr == ADDR_SETUP;
  assign full = reg_rdata[5:0] == CNT_FULL;
  assign ge = thr_r != 6'h00 && reg_rdata[5:0] >= thr_r;
  // threshold only lands in standby, mode lands always
  always_ff @(posedge sys_clk or negedge rstn)
    if (!rstn)
      {md_r, thr_r} <= 8'h00;
    else if (sw)
      {md_r, thr_r} <= active_mode ? {reg_wdata[7:6], thr_r} : reg_wdata;
  AST_PLAIN: assert property (pl |=> reg_rdata == $past(plain_status))
    else $error("plain status not shown");
  AST_ZERO: assert property (zr |=> reg_rdata == 8'h00)
    else $error("reserved read not zero");
  AST_IRQ: assert property (st && !sample_strobe |=> !buffer_irq_bit)
    else $error("irq bit kept after status read");
  AST_CNT: assert property (st |=> reg_rdata[5:0] <= CNT_FULL)
    else $error("count above depth");
  AST_OVF: assert property (nt |=> reg_rdata[OVF_BIT] == full)
    else $error("overflow flag wrong");
  AST_LVL: assert property (nt |=> reg_rdata[LVL_BIT] == ge)
    else $error("level flag wrong");
  AST_TRIG: assert property (tr |=> reg_rdata[7:6] != 2'b10)
    else $error("overflow before trigger");
  AST_EN: assert property (sw |=> buffer_enabled == (md_r != 2'h0))
    else $error("enable does not follow mode");
  cover property (st ##1 reg_rdata[OVF_BIT]);
  cover property (tr ##1 reg_rdata[LVL_BIT]);
  cover property (zr);
endmodule // fifo_chk
bind sample_fifo_control fifo_chk i_fifo_chk (.sys_clk, .rstn, .active_mode,
  .sample_strobe, .plain_status, .reg_rd, .reg_wr, .reg_addr, .reg_wdata,
  .reg_rdata, .buffer_irq_bit, .buffer_enabled);
`default_nettype wire

// File: tb/host_model.sv
`default_nettype none
module host_model
  import sample_fifo_pkg::*;
(
  input  wire logic       sys_clk,
  input  wire logic       reg_rvalid,
  input  wire logic [7:0] reg_rdata,
  output var  logic       reg_rd,
  output var  logic       reg_wr,
  output var  logic [7:0] reg_addr,
  output var  logic [7:0] reg_wdata
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [7:0] q[$];
  int         miss = 0;
  initial {reg_rd, reg_wr, reg_addr, reg_wdata} = 18'h0_0000;
  // idle bus shows inverted values, never the stale request
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    {reg_addr, reg_wdata, reg_wr} = {a, d, 1'b1};
    @(negedge sys_clk);
    {reg_addr, reg_wdata, reg_wr} = {~a, ~d, 1'b0};
    @(negedge sys_clk);
  endtask
  // one byte a cycle, strobe held through the whole burst
  task automatic rd(input logic [7:0] a, input int n);
    q.delete();
    {reg_addr, reg_rd} = {a, 1'b1};
    repeat (n)
    begin
      @(negedge sys_clk);
      if (reg_rvalid !== 1'b1) miss++;
      q.push_back(reg_rdata);
    end
    {reg_addr, reg_rd} = {~a, 1'b0};
    @(negedge sys_clk);
  endtask
  task automatic set_mode(input logic [1:0] m, input logic [5:0] t);
    wr(ADDR_SETUP, {2'h0, t});
    if (m != 2'h0) wr(ADDR_SETUP, {m, t});
  endtask
endmodule // host_model
`default_nettype wire

// File: tb/tb_top.sv
`default_nettype none
module tb_top
  import sample_fifo_pkg::*;
();
  timeunit 1ns;
  timeprecision 1ps;
  logic       sys_clk = 1'b0;
  logic       rstn = 1'b0;
  logic       active_mode = 1'b0;
  logic       rate_change = 1'b0;
  logic       sample_strobe = 1'b0;
  logic [7:0] sample_data = 8'h00;
  logic [7:0] plain_status = 8'h00;
  logic [7:0] plain_data = 8'h00;
  logic [3:0] embedded_irqs = 4'h0;
  logic       reg_rd, reg_wr, reg_rvalid, buffer_irq_bit, buffer_enabled;
  logic [7:0] reg_addr, reg_wdata, reg_rdata;
  int         err_total = 0;
  int         checks = 0;
  int         seed = 32'hb5f0_32fa;
  logic [7:0] mdl[$];
  logic [1:0] md = 2'h0;
  logic [5:0] thr = 6'h00;
  logic [5:0] t;
  logic       trg = 1'b0;
  always #12.5 sys_clk = ~sys_clk;
  sample_fifo_control i_sample_fifo_control (.sys_clk, .rstn, .active_mode,
    .rate_change, .sample_strobe, .sample_data, .plain_status, .plain_data,
    .embedded_irqs, .reg_rd, .reg_wr, .reg_addr, .reg_wdata, .reg_rdata,
    .reg_rvalid, .buffer_irq_bit, .buffer_enabled);
  host_model i_host_model (.sys_clk, .reg_rvalid, .reg_rdata, .reg_rd,
    .reg_wr, .reg_addr, .reg_wdata);
  task automatic chk(input logic [7:0] seen, exp, input string what);
    checks++;
    if (seen !== exp)
    begin
      err_total++;
      $display("mismatch %s exp %h seen %h", what, exp, seen);
    end
  endtask
  function automatic logic [7:0] exp_st();
    logic [5:0] c;
    c = 6'(mdl.size());
    if (md == MODE_TRIG) return {trg && c == CNT_FULL, trg, c};
    return {c == CNT_FULL, thr != 6'h00 && c >= thr, c};
  endfunction
  task automatic cfg(input logic [1:0] m, input logic [5:0] x);
    i_host_model.set_mode(m, x);
    md = m;
    if (!active_mode) thr = x;
    trg = 1'b0;
    mdl.delete();
  endtask
  // pre-trigger keeps only thr samples; fill and post-trigger stop at full
  task automatic push(input int n);
    sample_strobe = 1'b1;
    repeat (n)
    begin
      sample_data = 8'($random(seed));
      if (md == MODE_FILL || (md == MODE_TRIG && trg))
      begin
        if (mdl.size() < DEPTH) mdl.push_back(sample_data);
      end
      else
      begin
        mdl.push_back(sample_data);
        if (mdl.size() > ((md == MODE_TRIG) ? int'(thr) : DEPTH))
          void'(mdl.pop_front());
      end
      @(negedge sys_clk);
    end
    sample_strobe = 1'b0;
    @(negedge sys_clk);
  endtask
  task automatic st_chk();
    i_host_model.rd(ADDR_STATUS, 1);
    chk(i_host_model.q[0], exp_st(), "status");
  endtask
  task automatic drain(input int n);
    i_host_model.rd(ADDR_DATA_HEAD, n);
    foreach (i_host_model.q[i])
      chk(i_host_model.q[i], mdl.pop_front(), "data");
  endtask
  task automatic end_sim();
    err_total += i_host_model.miss;
    $display("checks %0d mismatches %0d", checks, err_total);
    if (err_total == 0 && checks > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask
  initial
  begin
    repeat (20000) @(posedge sys_clk);
    err_total++;
    end_sim();
  end
  initial
  begin
    repeat (8) @(negedge sys_clk);
    rstn = 1'b1;
    @(negedge sys_clk);
    plain_status = 8'($random(seed));
    plain_data = 8'($random(seed));
    i_host_model.rd(ADDR_STATUS, 1);
    chk(i_host_model.q[0], plain_status, "plain status");
    i_host_model.rd(ADDR_DATA_HEAD, 1);
    chk(i_host_model.q[0], plain_data, "plain data");
    $display("test off done");
    t = 6'(1 + {$random(seed)} % 30);
    cfg(MODE_FILL, t);
    push(35);
    st_chk();
    chk(8'(buffer_irq_bit), 8'h00, "irq");
    st_chk();
    drain(DEPTH - int'(t));
    st_chk();
    drain(1);
    st_chk();
    push(1);
    chk(8'(buffer_irq_bit), 8'h01, "irq");
    for (int a = 2; a <= 6; a++)
    begin
      i_host_model.rd(8'(a), 1);
      chk(i_host_model.q[0], 8'h00, "zero reg");
    end
    $display("test fill done");
    cfg(MODE_CIRC, 6'h00);
    push(40);
    st_chk();
    drain(8);
    push(3);
    st_chk();
    rate_change = 1'b1;
    @(negedge sys_clk);
    rate_change = 1'b0;
    mdl.delete();
    st_chk();
    push(4);
    active_mode = 1'b1;
    @(negedge sys_clk);
    mdl.delete();
    st_chk();
    push(4);
    cfg(MODE_CIRC, 6'h05);
    push(6);
    st_chk();
    i_host_model.rd(ADDR_SETUP, 1);
    chk(i_host_model.q[0], {md, thr}, "setup");
    active_mode = 1'b0;
    $display("test circular done");
    for (int k = 0; k < 4; k++)
    begin
      t = (k == 0) ? 6'h00 : 6'(1 + {$random(seed)} % 30);
      cfg(MODE_TRIG, t);
      i_host_model.wr(ADDR_TRIG_CFG, 8'(1 << (k + 2)));
      i_host_model.rd(ADDR_TRIG_CFG, 1);
      chk(i_host_model.q[0], 8'(1 << (k + 2)), "trig cfg");
      embedded_irqs = 4'(~(1 << k));
      push(40);
      st_chk();
      embedded_irqs = 4'hf;
      trg = 1'b1;
      repeat (2) @(negedge sys_clk);
      push(40);
      st_chk();
      drain(DEPTH);
      embedded_irqs = 4'h0;
    end
    $display("test trigger done");
    end_sim();
  end
endmodule // tb_top
`default_nettype wire
